// file: logic/dsa_pkg.sv
// Constants and types shared by the data-space access logic.
// Functional notes
// - Separate read and write address generators.
// - Byte pointers are 16 bits, 64 Kbyte space.
// - Pointer bit 15 selects program-space window region.
// - Only 4 Kbytes RAM; outside RAM and live special registers reads zero.
// - Low byte even address, high byte odd.
// - Byte read selects lane, returns low lane.
// - Shared word decode, separate byte write strobes.
// - Odd-address word access raises address error.
// - Misaligned read still completes before trap.
// - Misaligned write executes but store suppressed.
// - Post-increment adds 1 byte, 2 word.
// - Byte load writes working register low byte only.
// - Sign-widen and zero-widen operations provided.
// - Bytes 0 to 0x0FFF decode special registers.
// - Unused special register addresses read zero.
// - Near region reached by 13-bit direct field.
// - Full space by 16-bit direct or pointer.
package dsa_pkg;

  localparam int PTR_W = 16;
  localparam int NEAR_W = 13;
  localparam int RAM_AW = 11;
  localparam int RAM_WORDS = 2048;
  localparam logic [3:0] SFR_PAGE = 4'h0;
  localparam logic [3:0] RAM_PAGE = 4'h1;
  localparam int PAGE_MSB = 15;
  localparam int PAGE_LSB = 12;
  localparam int REGION_BIT = 15;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONES_BYTE = 8'hFF;

  // Addressing modes of one address generator.
  typedef enum logic [1:0] {
    DSA_NEAR13,
    DSA_DIRECT16,
    DSA_INDIRECT,
    DSA_POSTINC
  } dsa_mode_e;

endpackage : dsa_pkg

// file: logic/dsa_core.sv
// Data-space access logic: decode, byte lanes, zero fill and address error.
`timescale 1ns/1ps
module dsa_core (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic rd_req,
  input wire logic rd_byte,
  input wire dsa_pkg::dsa_mode_e rd_mode,
  input wire logic [15:0] rd_field,
  input wire logic [15:0] rd_source_pointer_reg,
  input wire logic wr_req,
  input wire logic wr_byte,
  input wire dsa_pkg::dsa_mode_e wr_mode,
  input wire logic [15:0] wr_field,
  input wire logic [15:0] wr_source_pointer_reg,
  input wire logic [15:0] wr_data,
  input wire logic [15:0] sfr_rd_data,
  input wire logic sfr_rd_hit,
  input wire logic widen_req,
  input wire logic widen_sign,
  input wire logic [15:0] widen_src,
  output logic rd_valid_r,
  output logic [15:0] rd_data_r,
  output logic wreg_we_lo_r,
  output logic wreg_we_hi_r,
  output logic rd_ptr_upd_en_r,
  output logic [15:0] rd_ptr_upd_r,
  output logic wr_done_r,
  output logic wr_ptr_upd_en_r,
  output logic [15:0] wr_ptr_upd_r,
  output logic sfr_rd_en_r,
  output logic [10:0] sfr_rd_addr_r,
  output logic sfr_wr_lo_r,
  output logic sfr_wr_hi_r,
  output logic [10:0] sfr_wr_addr_r,
  output logic [15:0] sfr_wr_data_r,
  output logic window_hit_r,
  output logic addr_err_r,
  output logic addr_err_wr_r,
  output logic widen_done_r,
  output logic [15:0] widen_res_r
);

  ////////////////////////////////////////////////////////////////////////////

  logic rst_meta_n_r;
  logic rst_sync_n_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n_r <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end else begin
      rst_meta_n_r <= 1'b1;
      rst_sync_n_r <= rst_meta_n_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // A near field is only 13 bits wide, so it reaches the low 8 Kbytes.
  function automatic logic [15:0] form_ptr(
    input dsa_pkg::dsa_mode_e mode,
    input logic [15:0] field,
    input logic [15:0] preg
  );
    logic [15:0] ptr;
    ptr = preg;
    unique case (mode)
      dsa_pkg::DSA_NEAR13: ptr = {3'h0, field[dsa_pkg::NEAR_W-1:0]};
      dsa_pkg::DSA_DIRECT16: ptr = field;
      dsa_pkg::DSA_INDIRECT: ptr = preg;
      dsa_pkg::DSA_POSTINC: ptr = preg;
    endcase
    return ptr;
  endfunction : form_ptr

  function automatic logic [15:0] step_ptr(
    input logic [15:0] preg,
    input logic is_byte
  );
    return preg + (is_byte ? dsa_pkg::BYTE_STEP : dsa_pkg::WORD_STEP);
  endfunction : step_ptr

  // Two independent generators, one for each direction.
  wire [15:0] rptr = form_ptr(rd_mode, rd_field, rd_source_pointer_reg);
  wire [15:0] wptr = form_ptr(wr_mode, wr_field, wr_source_pointer_reg);
  wire rd_inc = rd_mode == dsa_pkg::DSA_POSTINC;
  wire wr_inc = wr_mode == dsa_pkg::DSA_POSTINC;
  wire [15:0] rd_next = step_ptr(rd_source_pointer_reg, rd_byte);
  wire [15:0] wr_next = step_ptr(wr_source_pointer_reg, wr_byte);

  // Bit 15 splits implemented memory from the window region.
  wire r_window = rptr[dsa_pkg::REGION_BIT];
  wire w_window = wptr[dsa_pkg::REGION_BIT];
  wire [3:0] r_page = rptr[dsa_pkg::PAGE_MSB:dsa_pkg::PAGE_LSB];
  wire [3:0] w_page = wptr[dsa_pkg::PAGE_MSB:dsa_pkg::PAGE_LSB];
  wire r_sfr = r_page == dsa_pkg::SFR_PAGE;
  wire w_sfr = w_page == dsa_pkg::SFR_PAGE;
  wire r_ram = r_page == dsa_pkg::RAM_PAGE;
  wire w_ram = w_page == dsa_pkg::RAM_PAGE;
  wire [10:0] r_word = rptr[11:1];
  wire [10:0] w_word = wptr[11:1];
  wire r_mis = rd_req && !rd_byte && rptr[0];
  wire w_mis = wr_req && !wr_byte && wptr[0];

  // Even byte is the low lane, odd byte the high lane.
  wire w_lo = wr_req && (wr_byte ? !wptr[0] : !w_mis);
  wire w_hi = wr_req && (wr_byte ? wptr[0] : !w_mis);
  wire [15:0] w_lanes = wr_byte ? {wr_data[7:0], wr_data[7:0]} : wr_data;

  ////////////////////////////////////////////////////////////////////////////

  // Storage has no reset; contents are undefined until written.
  logic [15:0] ram [dsa_pkg::RAM_WORDS];
  logic [15:0] ram_q_r;

  always_ff @(posedge clock) begin
    if (w_ram && w_lo) begin
      ram[w_word][7:0] <= w_lanes[7:0];
    end
    if (w_ram && w_hi) begin
      ram[w_word][15:8] <= w_lanes[15:8];
    end
    ram_q_r <= ram[r_word];
  end

  ////////////////////////////////////////////////////////////////////////////

  // Read stage one holds the decode while the register space answers.
  logic rd_s1_r;
  logic rd_byte_r;
  logic rd_lane_r;
  logic rd_mis_r;
  logic rd_ram_r;
  logic rd_sfr_r;

  always_ff @(posedge clock or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      rd_s1_r <= 1'b0;
      rd_byte_r <= 1'b0;
      rd_lane_r <= 1'b0;
      rd_mis_r <= 1'b0;
      rd_ram_r <= 1'b0;
      rd_sfr_r <= 1'b0;
      sfr_rd_en_r <= 1'b0;
      sfr_rd_addr_r <= '0;
    end else begin
      rd_s1_r <= rd_req;
      rd_byte_r <= rd_byte;
      rd_lane_r <= rptr[0];
      rd_mis_r <= r_mis;
      rd_ram_r <= rd_req && r_ram;
      rd_sfr_r <= rd_req && r_sfr;
      sfr_rd_en_r <= rd_req && r_sfr;
      sfr_rd_addr_r <= r_word;
    end
  end

  // Anything not answered by RAM or a live register reads as zero.
  wire [15:0] src_word = rd_ram_r ? ram_q_r :
                         (rd_sfr_r && sfr_rd_hit) ? sfr_rd_data :
                         dsa_pkg::ZERO_WORD;
  wire [7:0] sel_byte = rd_lane_r ? src_word[15:8] : src_word[7:0];
  wire [15:0] rd_data_nxt = rd_byte_r ? {dsa_pkg::ZERO_BYTE, sel_byte} :
                            src_word;

  ////////////////////////////////////////////////////////////////////////////

  wire [15:0] sext_val = {{8{widen_src[7]}}, widen_src[7:0]};
  wire [15:0] zext_val = {dsa_pkg::ZERO_BYTE, widen_src[7:0]};

  always_ff @(posedge clock or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      rd_valid_r <= 1'b0;
      rd_data_r <= dsa_pkg::ZERO_WORD;
      wreg_we_lo_r <= 1'b0;
      wreg_we_hi_r <= 1'b0;
      rd_ptr_upd_en_r <= 1'b0;
      rd_ptr_upd_r <= dsa_pkg::ZERO_WORD;
      window_hit_r <= 1'b0;
    end else begin
      rd_valid_r <= rd_s1_r;
      rd_data_r <= rd_data_nxt;
      wreg_we_lo_r <= rd_s1_r;
      wreg_we_hi_r <= rd_s1_r && !rd_byte_r;
      rd_ptr_upd_en_r <= rd_req && rd_inc;
      rd_ptr_upd_r <= rd_next;
      window_hit_r <= (rd_req && r_window) || (wr_req && w_window);
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      wr_done_r <= 1'b0;
      wr_ptr_upd_en_r <= 1'b0;
      wr_ptr_upd_r <= dsa_pkg::ZERO_WORD;
      sfr_wr_lo_r <= 1'b0;
      sfr_wr_hi_r <= 1'b0;
      sfr_wr_addr_r <= '0;
      sfr_wr_data_r <= dsa_pkg::ZERO_WORD;
    end else begin
      wr_done_r <= wr_req;
      wr_ptr_upd_en_r <= wr_req && wr_inc;
      wr_ptr_upd_r <= wr_next;
      sfr_wr_lo_r <= w_sfr && w_lo;
      sfr_wr_hi_r <= w_sfr && w_hi;
      sfr_wr_addr_r <= w_word;
      sfr_wr_data_r <= w_lanes;
    end
  end

  // A read error waits for its data so the instruction completes first.
  always_ff @(posedge clock or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      addr_err_r <= 1'b0;
      addr_err_wr_r <= 1'b0;
      widen_done_r <= 1'b0;
      widen_res_r <= dsa_pkg::ZERO_WORD;
    end else begin
      addr_err_r <= (rd_s1_r && rd_mis_r) || w_mis;
      addr_err_wr_r <= w_mis;
      widen_done_r <= widen_req;
      widen_res_r <= widen_sign ? sext_val : zext_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_sync_n_r);

  sequence seq_rd_issue;
    rd_req && !rd_byte && rptr[0];
  endsequence

  sequence seq_rd_finish;
    rd_s1_r ##1 (rd_valid_r && addr_err_r);
  endsequence

  a_rd_two_stage: assert property (rd_req |=> rd_s1_r ##1 rd_valid_r)
    else $error("read answer not two cycles after request");

  a_mis_read_trap: assert property (seq_rd_issue |=> seq_rd_finish)
    else $error("misaligned read did not complete with error");

  a_mis_write_gate: assert property (w_mis |=>
    !sfr_wr_lo_r && !sfr_wr_hi_r && addr_err_r && addr_err_wr_r)
    else $error("misaligned write not suppressed");

  a_byte_low_lane: assert property (rd_valid_r && $past(rd_byte_r) |->
    rd_data_r[15:8] == dsa_pkg::ZERO_BYTE)
    else $error("byte read high lane not zero");

  a_window_zero: assert property (rd_req && r_window |-> ##2
    rd_data_r == dsa_pkg::ZERO_WORD)
    else $error("window region read not zero");

  a_byte_one_strobe: assert property (wr_req && wr_byte && w_sfr |=>
    sfr_wr_lo_r != sfr_wr_hi_r)
    else $error("byte write strobes both or neither lane");

  a_postinc_step: assert property (wr_req && wr_inc |=>
    wr_ptr_upd_en_r && wr_ptr_upd_r == $past(wr_source_pointer_reg) +
    ($past(wr_byte) ? dsa_pkg::BYTE_STEP : dsa_pkg::WORD_STEP))
    else $error("post-increment step wrong");

  a_wreg_low_only: assert property (rd_req && rd_byte |-> ##2
    wreg_we_lo_r && !wreg_we_hi_r)
    else $error("byte load touched high byte");

  a_sign_widen: assert property (widen_req && widen_sign |=>
    widen_res_r[15:8] == ($past(sext_val[7]) ? dsa_pkg::ONES_BYTE :
    dsa_pkg::ZERO_BYTE))
    else $error("sign widen high byte wrong");

  a_err_pulse: assert property (!rd_req && !wr_req ##1
    !rd_req && !wr_req |=> !addr_err_r)
    else $error("address error without a cause");

endmodule : dsa_core

// file: testbench/dsa_sfr_model.sv
// Register-space model that answers the access logic's register port.
`timescale 1ns/1ps
module dsa_sfr_model (
  input wire logic clock,
  input wire logic rd_en,
  input wire logic [10:0] rd_addr,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [10:0] wr_addr,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data,
  output logic rd_hit
);
  // Four words exist; outside them the bus churns so no zero fill is faked.
  logic [15:0] regs_r [4] = '{4{16'h0000}};
  logic [15:0] noise_r = 16'hA5C3;
  logic [10:0] addr_r = 11'h000;
  logic sel_r = 1'b0;
  wire logic [10:0] addr = rd_en ? rd_addr : addr_r;
  wire logic live = (rd_en || sel_r) && addr < 11'h004;
  assign rd_data = live ? regs_r[addr[1:0]] : noise_r;
  assign rd_hit = live;
  always @(posedge clock) begin
    noise_r <= ~{noise_r[14:0], noise_r[15]};
    sel_r <= rd_en;
    if (rd_en) begin
      addr_r <= rd_addr;
    end
    if (wr_lo && wr_addr < 11'h004) begin
      regs_r[wr_addr[1:0]][7:0] <= wr_data[7:0];
    end
    if (wr_hi && wr_addr < 11'h004) begin
      regs_r[wr_addr[1:0]][15:8] <= wr_data[15:8];
    end
  end
endmodule : dsa_sfr_model

// file: testbench/test_secondary_core_data_space_access.sv
// Self-checking bench for the data-space access logic.
`timescale 1ns/1ps
module test_secondary_core_data_space_access;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic rd_req = 1'b0, rd_byte = 1'b0, wr_req = 1'b0, wr_byte = 1'b0;
  dsa_pkg::dsa_mode_e rd_mode = dsa_pkg::DSA_DIRECT16;
  dsa_pkg::dsa_mode_e wr_mode = dsa_pkg::DSA_DIRECT16;
  logic [15:0] rd_field = 16'h0000, rd_source_pointer_reg = 16'h0000;
  logic [15:0] wr_field = 16'h0000, wr_source_pointer_reg = 16'h0000;
  logic [15:0] wr_data = 16'h0000, widen_src = 16'h0000, sfr_rd_data;
  logic widen_req = 1'b0, widen_sign = 1'b0, sfr_rd_hit;
  logic rd_valid_r, wreg_we_lo_r, wreg_we_hi_r, rd_ptr_upd_en_r;
  logic wr_done_r, wr_ptr_upd_en_r, sfr_rd_en_r, sfr_wr_lo_r, sfr_wr_hi_r;
  logic window_hit_r, addr_err_r, addr_err_wr_r, widen_done_r;
  logic [15:0] rd_data_r, rd_ptr_upd_r, wr_ptr_upd_r, sfr_wr_data_r;
  logic [15:0] widen_res_r, rpu, wpu, d;
  logic [10:0] sfr_rd_addr_r, sfr_wr_addr_r;
  logic err = 1'b0, err_wr = 1'b0, win = 1'b0, we_lo, we_hi;
  int failures = 0, checks_done = 0;
  always #2.5 clock = ~clock;
  dsa_core DUT (.*);
  dsa_sfr_model u_sfr (.clock(clock), .rd_en(sfr_rd_en_r),
    .rd_addr(sfr_rd_addr_r), .wr_lo(sfr_wr_lo_r), .wr_hi(sfr_wr_hi_r),
    .wr_addr(sfr_wr_addr_r), .wr_data(sfr_wr_data_r),
    .rd_data(sfr_rd_data), .rd_hit(sfr_rd_hit));
  // Events are one-cycle pulses, so they are latched for later judging.
  always @(posedge clock) begin
    err <= err | addr_err_r;
    err_wr <= err_wr | addr_err_wr_r;
    win <= win | window_hit_r;
    if (rd_ptr_upd_en_r) begin
      rpu <= rd_ptr_upd_r;
    end
    if (wr_ptr_upd_en_r) begin
      wpu <= wr_ptr_upd_r;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic await(ref logic sig);
    for (int n = 0; n < 8 && sig !== 1'b1; n++) begin
      @(negedge clock);
    end
    if (sig !== 1'b1) begin
      failures++;
      $display("[ERR] %0t no answer", $time);
      end_of_test;
    end
  endtask : await
  // Field modes get the inverse pointer, pointer modes the inverse field.
  task automatic rd(input dsa_pkg::dsa_mode_e m, input logic b,
                    input logic [15:0] a);
    {err, err_wr, win} = 3'h0;
    rd_mode = m;
    rd_byte = b;
    rd_field = m > dsa_pkg::DSA_DIRECT16 ? ~a : a;
    rd_source_pointer_reg = m > dsa_pkg::DSA_DIRECT16 ? a : ~a;
    rd_req = 1'b1;
    @(negedge clock);
    rd_req = 1'b0;
    await(rd_valid_r);
    d = rd_data_r;
    {we_lo, we_hi} = {wreg_we_lo_r, wreg_we_hi_r};
    @(negedge clock);
  endtask : rd
  task automatic wr(input dsa_pkg::dsa_mode_e m, input logic b,
                    input logic [15:0] a, input logic [15:0] v);
    {err, err_wr, win} = 3'h0;
    wr_mode = m;
    wr_byte = b;
    wr_field = m > dsa_pkg::DSA_DIRECT16 ? ~a : a;
    wr_source_pointer_reg = m > dsa_pkg::DSA_DIRECT16 ? a : ~a;
    wr_data = v;
    wr_req = 1'b1;
    @(negedge clock);
    wr_req = 1'b0;
    await(wr_done_r);
    @(negedge clock);
  endtask : wr
  //////////////////////////////////////////////////////////////////////////
  task automatic t_lanes;
    wr(dsa_pkg::DSA_DIRECT16, 1'b0, 16'h1002, 16'h1234);
    wr(dsa_pkg::DSA_DIRECT16, 1'b1, 16'h1003, 16'h55AB);
    rd(dsa_pkg::DSA_DIRECT16, 1'b0, 16'h1002);
    chk(d, 16'hAB34);
    chk({14'h0, we_lo, we_hi}, 16'h0003);
    rd(dsa_pkg::DSA_DIRECT16, 1'b1, 16'h1003);
    chk(d, 16'h00AB);
    chk({14'h0, we_lo, we_hi}, 16'h0002);
    rd(dsa_pkg::DSA_DIRECT16, 1'b1, 16'h1002);
    chk(d, 16'h0034);
    $display("lanes test done");
  endtask : t_lanes
  task automatic t_misalign;
    wr(dsa_pkg::DSA_DIRECT16, 1'b0, 16'h1003, 16'hFFFF);
    chk({14'h0, err, err_wr}, 16'h0003);
    rd(dsa_pkg::DSA_DIRECT16, 1'b0, 16'h1002);
    chk(d, 16'hAB34);
    rd(dsa_pkg::DSA_DIRECT16, 1'b0, 16'h1003);
    chk({14'h0, err, err_wr}, 16'h0002);
    $display("misalign test done");
  endtask : t_misalign
  task automatic t_zero;
    rd(dsa_pkg::DSA_DIRECT16, 1'b0, 16'h8000);
    chk({d[14:0], win}, 16'h0001);
    rd(dsa_pkg::DSA_DIRECT16, 1'b0, 16'h2000);
    chk(d, 16'h0000);
    wr(dsa_pkg::DSA_DIRECT16, 1'b0, 16'h1FFE, 16'hBEEF);
    rd(dsa_pkg::DSA_DIRECT16, 1'b0, 16'h1FFE);
    chk(d, 16'hBEEF);
    rd(dsa_pkg::DSA_DIRECT16, 1'b0, 16'h0100);
    chk(d, 16'h0000);
    wr(dsa_pkg::DSA_DIRECT16, 1'b1, 16'h0003, 16'h00C0);
    rd(dsa_pkg::DSA_DIRECT16, 1'b0, 16'h0002);
    chk(d, 16'hC000);
    $display("zero test done");
  endtask : t_zero
  task automatic t_modes;
    rd(dsa_pkg::DSA_NEAR13, 1'b0, 16'hF002);
    chk(d, 16'hAB34);
    rd(dsa_pkg::DSA_INDIRECT, 1'b0, 16'h1002);
    chk(d, 16'hAB34);
    rd(dsa_pkg::DSA_POSTINC, 1'b1, 16'h1003);
    chk(rpu, 16'h1004);
    rd(dsa_pkg::DSA_POSTINC, 1'b0, 16'h1002);
    chk(rpu, 16'h1004);
    wr(dsa_pkg::DSA_POSTINC, 1'b0, 16'h1FFE, 16'h0000);
    chk(wpu, 16'h2000);
    $display("modes test done");
  endtask : t_modes
  task automatic t_widen(input logic s, input logic [15:0] v,
                         input logic [15:0] exp);
    widen_sign = s;
    widen_src = v;
    widen_req = 1'b1;
    @(negedge clock);
    widen_req = 1'b0;
    await(widen_done_r);
    chk(widen_res_r, exp);
    @(negedge clock);
  endtask : t_widen
  initial begin
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    repeat (3) @(negedge clock);
    t_lanes;
    t_misalign;
    t_zero;
    t_modes;
    t_widen(1'b1, 16'h1280, 16'hFF80);
    t_widen(1'b1, 16'h347F, 16'h007F);
    t_widen(1'b0, 16'h12F0, 16'h00F0);
    $display("widen test done");
    end_of_test;
  end
endmodule : test_secondary_core_data_space_access
